// ### src/sos_pkg.sv
// Constants, register map and carrier types of the sync output stage.
package sos_pkg;
	// ------------------------------------------------------------
	// Register port geometry.
	// ------------------------------------------------------------
	localparam int unsigned AW = 8; // Address width.
	localparam int unsigned DW = 8; // Data width.
	localparam logic [AW-1:0] ADR_PHASE = 8'h04; // Sampling phase.
	localparam logic [AW-1:0] ADR_VS_CTRL = 8'h14; // Vertical sync control.
	localparam logic [AW-1:0] ADR_VS_DUR = 8'h15; // Vertical sync duration in lines.
	localparam logic [AW-1:0] ADR_SLICE = 8'h1D; // Sliced sync source select.
	localparam logic [AW-1:0] ADR_HS_CTRL = 8'h30; // Horizontal sync polarity.
	localparam logic [AW-1:0] ADR_HS_WIDTH = 8'h31; // Horizontal sync width in cycles.
	localparam logic [AW-1:0] ADR_STATUS = 8'h32; // Read-only status.
	// ------------------------------------------------------------
	// Field positions.
	// ------------------------------------------------------------
	localparam int unsigned VS_DUR_BIT = 1; // Programmed duration when set.
	localparam int unsigned VS_POL_BIT = 2; // Invert vertical sync output when set.
	localparam int unsigned VS_SEP_BIT = 3; // Separated sync when set, else pass through.
	localparam int unsigned HS_POL_BIT = 0; // Invert horizontal sync output when set.
	localparam int unsigned PH_TAP_HI = 4; // Phase bits that pick the delay tap.
	localparam int unsigned PH_TAP_LO = 2;
	localparam int unsigned ST_FIELD_BIT = 0; // Status: odd field.
	localparam int unsigned ST_ADDR_BIT = 1; // Status: captured address bit.
	localparam int unsigned ST_VS_BIT = 2; // Status: vertical sync output level.
	// ------------------------------------------------------------
	// Reset values and sizes.
	// ------------------------------------------------------------
	localparam logic [DW-1:0] RST_ZERO = 8'h00;
	localparam logic [DW-1:0] RST_HS_WIDTH = 8'h20;
	localparam logic [DW-1:0] RST_VS_DUR = 8'h06;
	localparam int unsigned PIPE_DEPTH = 8; // Delay taps for phase shifting.
	localparam int unsigned SEP_CYC = 64; // Broad pulse length that marks vertical sync.
	localparam int unsigned LW = 16; // Line position counter width.
	localparam logic [LW-1:0] LINE_ZERO = 16'h0000;
	localparam logic [LW-1:0] LINE_ONE = 16'h0001;
	// ------------------------------------------------------------
	// Encodings and carriers.
	// ------------------------------------------------------------
	localparam logic [1:0] SL_RAW_EMB = 2'h0; // Raw embedded sync.
	localparam logic [1:0] SL_RAW_HS = 2'h1; // Raw horizontal sync.
	localparam logic [1:0] SL_REGEN = 2'h2; // Regenerated horizontal sync.
	localparam logic [1:0] SL_FILT = 2'h3; // Filtered horizontal sync.
	typedef enum logic [1:0] {STRAP_WAIT = 2'b01, STRAP_DONE = 2'b10} sos_strap_t;
	typedef enum logic [1:0] {VG_IDLE = 2'b01, VG_PULSE = 2'b10} sos_vgen_t;
	typedef struct packed {
		logic [9:0] red;
		logic [9:0] green;
		logic [9:0] blue;
	} sos_pixel_t;
	typedef struct packed {
		sos_pixel_t pix;
		logic clk;
		logic hs;
	} sos_stage_t;
endpackage

// ### src/sos_sync_output_select.sv
// Sync output stage: regenerated syncs, sliced sync, field flag, address strap.
`timescale 1ns/100ps
// Behaviour
// - Horizontal sync output regenerated, sampling-clock aligned.
// - Software sets horizontal polarity and width.
// - Horizontal sync fixed to data and clock.
// - Vertical output separated or passed through.
// - One bit inverts vertical sync output.
// - Vertical width from source or programmed.
// - Shared pin gives address low bit.
// - Pin sampled at power-up; pull-up gives one.
// - Strap and vertical sync roles independent.
// - Two-bit field picks sliced sync source.
// - Sliced sync only selected, never processed.
// - Field flag shows odd or even field.
// - Phase change shifts data, clock, sync together.
module sos_sync_output_select #(
	parameter int unsigned PIPE_DEPTH = sos_pkg::PIPE_DEPTH,
	parameter int unsigned SEP_CYC = sos_pkg::SEP_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [sos_pkg::AW-1:0] reg_addr,
	input wire logic [sos_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [sos_pkg::DW-1:0] reg_rdata,
	input wire logic horizontal_sync_in,
	input wire logic embedded_sync_in,
	input wire logic vsync_in,
	input wire logic pixel_clk_in,
	input wire sos_pkg::sos_pixel_t pixel_in,
	input wire logic vsync_or_addr_pin_i,
	output logic vsync_or_addr_pin_o,
	output logic vsync_or_addr_pin_oe_n,
	output logic regen_hsync_out,
	output logic pixel_data_clock_out,
	output sos_pkg::sos_pixel_t pixel_out,
	output logic sliced_sync_out,
	output logic field_odd_out,
	output logic address_lsb_strap
);
	localparam int unsigned TW = $clog2(PIPE_DEPTH); // Tap index width.

	// Rising edge of a level against its previous sample.
	function automatic logic rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

	// ------------------------------------------------------------
	// Register file.
	// ------------------------------------------------------------
	logic [sos_pkg::DW-1:0] phase_r, phase_nxt; // Sampling phase.
	logic [sos_pkg::DW-1:0] vs_ctrl_r, vs_ctrl_nxt; // Vertical sync control.
	logic [sos_pkg::DW-1:0] vs_dur_r, vs_dur_nxt; // Vertical duration in lines.
	logic [1:0] slice_r, slice_nxt; // Sliced sync source.
	logic [sos_pkg::DW-1:0] hs_ctrl_r, hs_ctrl_nxt; // Horizontal polarity.
	logic [sos_pkg::DW-1:0] hs_width_r, hs_width_nxt; // Horizontal width.
	logic [sos_pkg::DW-1:0] rdata_nxt; // Read data for the next cycle.
	logic field_r; // Odd field flag.
	logic strap_r; // Captured address bit.
	logic vsync_out_r; // Vertical sync output level.

	// Decodes writes into the control registers and reads into the data word.
	always_comb begin
		phase_nxt = phase_r;
		vs_ctrl_nxt = vs_ctrl_r;
		vs_dur_nxt = vs_dur_r;
		slice_nxt = slice_r;
		hs_ctrl_nxt = hs_ctrl_r;
		hs_width_nxt = hs_width_r;
		rdata_nxt = sos_pkg::RST_ZERO;
		if (reg_wr) begin
			unique case (reg_addr)
				sos_pkg::ADR_PHASE: phase_nxt = reg_wdata;
				sos_pkg::ADR_VS_CTRL: vs_ctrl_nxt = reg_wdata;
				sos_pkg::ADR_VS_DUR: vs_dur_nxt = reg_wdata;
				sos_pkg::ADR_SLICE: slice_nxt = reg_wdata[1:0];
				sos_pkg::ADR_HS_CTRL: hs_ctrl_nxt = reg_wdata;
				sos_pkg::ADR_HS_WIDTH: hs_width_nxt = reg_wdata;
				default: begin
					// Unmapped or read-only addresses ignore writes.
				end
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				sos_pkg::ADR_PHASE: rdata_nxt = phase_r;
				sos_pkg::ADR_VS_CTRL: rdata_nxt = vs_ctrl_r;
				sos_pkg::ADR_VS_DUR: rdata_nxt = vs_dur_r;
				sos_pkg::ADR_SLICE: rdata_nxt = {6'h00, slice_r};
				sos_pkg::ADR_HS_CTRL: rdata_nxt = hs_ctrl_r;
				sos_pkg::ADR_HS_WIDTH: rdata_nxt = hs_width_r;
				sos_pkg::ADR_STATUS: begin
					rdata_nxt[sos_pkg::ST_FIELD_BIT] = field_r;
					rdata_nxt[sos_pkg::ST_ADDR_BIT] = strap_r;
					rdata_nxt[sos_pkg::ST_VS_BIT] = vsync_out_r;
				end
				default: begin
					// Unmapped addresses read as zero.
				end
			endcase
		end
	end

	// Registers the control state; read data stand only in the cycle after a read.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			phase_r <= sos_pkg::RST_ZERO;
			vs_ctrl_r <= sos_pkg::RST_ZERO;
			vs_dur_r <= sos_pkg::RST_VS_DUR;
			slice_r <= sos_pkg::SL_RAW_EMB;
			hs_ctrl_r <= sos_pkg::RST_ZERO;
			hs_width_r <= sos_pkg::RST_HS_WIDTH;
			reg_rdata <= sos_pkg::RST_ZERO;
		end else if (clk_en) begin
			phase_r <= phase_nxt;
			vs_ctrl_r <= vs_ctrl_nxt;
			vs_dur_r <= vs_dur_nxt;
			slice_r <= slice_nxt;
			hs_ctrl_r <= hs_ctrl_nxt;
			hs_width_r <= hs_width_nxt;
			reg_rdata <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// Sync processing.
	// ------------------------------------------------------------
	logic hs_smp_r, hs_smp_nxt; // Previous raw horizontal sample.
	logic hs_filt_r, hs_filt_nxt; // Glitch-filtered horizontal sync.
	logic regen_r, regen_nxt; // Regenerated horizontal sync, active high.
	logic [sos_pkg::DW-1:0] hs_cnt_r, hs_cnt_nxt; // Remaining pulse cycles.
	logic [sos_pkg::LW-1:0] pos_r, pos_nxt; // Cycles since line start.
	logic [sos_pkg::LW-1:0] len_r, len_nxt; // Last measured line length.
	logic [sos_pkg::LW-1:0] emb_cnt_r, emb_cnt_nxt; // Embedded sync pulse length.
	logic sep_vs_r, sep_vs_nxt; // Vertical sync separated from composite.
	logic vs_src_prev_r; // Previous vertical source level.
	logic vs_src; // Selected vertical sync source.
	logic hs_rise; // Line start.
	logic vs_rise; // Field start.
	sos_pkg::sos_vgen_t vg_st_r, vg_st_nxt; // Programmed-duration generator.
	logic [sos_pkg::DW-1:0] vg_cnt_r, vg_cnt_nxt; // Lines left in the pulse.
	logic field_nxt;
	logic vsync_out_nxt;

	// Regenerates horizontal sync, separates vertical sync and tracks the field.
	always_comb begin
		hs_smp_nxt = horizontal_sync_in;
		// A level is accepted only after two equal samples.
		hs_filt_nxt = (horizontal_sync_in == hs_smp_r) ? hs_smp_r : hs_filt_r;
		hs_rise = rise(hs_filt_nxt, hs_filt_r);
		regen_nxt = regen_r;
		hs_cnt_nxt = hs_cnt_r;
		if (hs_rise) begin
			regen_nxt = 1'b1;
			hs_cnt_nxt = (hs_width_r == sos_pkg::RST_ZERO) ? sos_pkg::RST_ZERO :
				hs_width_r - 8'h01;
		end else if (hs_cnt_r != sos_pkg::RST_ZERO) begin
			hs_cnt_nxt = hs_cnt_r - 8'h01;
		end else begin
			regen_nxt = 1'b0;
		end
		pos_nxt = hs_rise ? sos_pkg::LINE_ZERO : pos_r + sos_pkg::LINE_ONE;
		len_nxt = hs_rise ? pos_r : len_r;
		// A broad embedded sync pulse marks the vertical interval.
		if (!embedded_sync_in) begin
			emb_cnt_nxt = sos_pkg::LINE_ZERO;
		end else if (emb_cnt_r != {sos_pkg::LW{1'b1}}) begin
			emb_cnt_nxt = emb_cnt_r + sos_pkg::LINE_ONE;
		end else begin
			emb_cnt_nxt = emb_cnt_r;
		end
		sep_vs_nxt = embedded_sync_in && (emb_cnt_r >= sos_pkg::LW'(SEP_CYC));
		vs_src = vs_ctrl_r[sos_pkg::VS_SEP_BIT] ? sep_vs_r : vsync_in;
		vs_rise = rise(vs_src, vs_src_prev_r);
		vg_st_nxt = vg_st_r;
		vg_cnt_nxt = vg_cnt_r;
		unique case (vg_st_r)
			sos_pkg::VG_IDLE: begin
				if (vs_rise && vs_ctrl_r[sos_pkg::VS_DUR_BIT]) begin
					vg_st_nxt = sos_pkg::VG_PULSE;
					vg_cnt_nxt = vs_dur_r;
				end
			end
			sos_pkg::VG_PULSE: begin
				// The pulse lasts the programmed number of lines.
				if (vg_cnt_r == sos_pkg::RST_ZERO || !vs_ctrl_r[sos_pkg::VS_DUR_BIT]) begin
					vg_st_nxt = sos_pkg::VG_IDLE;
				end else if (hs_rise) begin
					vg_cnt_nxt = vg_cnt_r - 8'h01;
				end
			end
			default: begin
				vg_st_nxt = sos_pkg::VG_IDLE;
			end
		endcase
		if (vs_ctrl_r[sos_pkg::VS_DUR_BIT]) begin
			vsync_out_nxt = vg_st_nxt == sos_pkg::VG_PULSE;
		end else begin
			vsync_out_nxt = vs_src;
		end
		vsync_out_nxt = vsync_out_nxt ^ vs_ctrl_r[sos_pkg::VS_POL_BIT];
		// A field starting in the first half of a line is the odd one.
		field_nxt = vs_rise ? (pos_r < (len_r >> 1)) : field_r;
	end

	// Registers the sync processing state.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hs_smp_r <= 1'b0;
			hs_filt_r <= 1'b0;
			regen_r <= 1'b0;
			hs_cnt_r <= sos_pkg::RST_ZERO;
			pos_r <= sos_pkg::LINE_ZERO;
			len_r <= sos_pkg::LINE_ZERO;
			emb_cnt_r <= sos_pkg::LINE_ZERO;
			sep_vs_r <= 1'b0;
			vs_src_prev_r <= 1'b0;
			vg_st_r <= sos_pkg::VG_IDLE;
			vg_cnt_r <= sos_pkg::RST_ZERO;
			vsync_out_r <= 1'b0;
			field_r <= 1'b0;
		end else if (clk_en) begin
			hs_smp_r <= hs_smp_nxt;
			hs_filt_r <= hs_filt_nxt;
			regen_r <= regen_nxt;
			hs_cnt_r <= hs_cnt_nxt;
			pos_r <= pos_nxt;
			len_r <= len_nxt;
			emb_cnt_r <= emb_cnt_nxt;
			sep_vs_r <= sep_vs_nxt;
			vs_src_prev_r <= vs_src;
			vg_st_r <= vg_st_nxt;
			vg_cnt_r <= vg_cnt_nxt;
			vsync_out_r <= vsync_out_nxt;
			field_r <= field_nxt;
		end
	end

	// ------------------------------------------------------------
	// Output stage, phase delay and address strap.
	// ------------------------------------------------------------
	sos_pkg::sos_stage_t pipe_r [PIPE_DEPTH]; // Common delay line.
	sos_pkg::sos_stage_t pipe_nxt [PIPE_DEPTH];
	logic [TW-1:0] tap; // Selected delay tap.
	sos_pkg::sos_strap_t strap_st_r, strap_st_nxt;
	logic strap_nxt;
	logic slice_nxt_out;

	// Data, clock and horizontal sync share one delay line and one tap.
	always_comb begin
		pipe_nxt[0] = '{pix: pixel_in, clk: pixel_clk_in, hs: regen_r};
		for (int i = 1; i < PIPE_DEPTH; i++) begin
			pipe_nxt[i] = pipe_r[i-1];
		end
		tap = TW'(phase_r[sos_pkg::PH_TAP_HI:sos_pkg::PH_TAP_LO]);
		// The sliced output is a bare selection with no further shaping.
		unique case (slice_r)
			sos_pkg::SL_RAW_EMB: slice_nxt_out = embedded_sync_in;
			sos_pkg::SL_RAW_HS: slice_nxt_out = horizontal_sync_in;
			sos_pkg::SL_REGEN: slice_nxt_out = regen_r;
			sos_pkg::SL_FILT: slice_nxt_out = hs_filt_r;
		endcase
		// The pin is released and read once, then driven with vertical sync.
		strap_st_nxt = sos_pkg::STRAP_DONE;
		strap_nxt = (strap_st_r == sos_pkg::STRAP_WAIT) ? vsync_or_addr_pin_i : strap_r;
	end

	// Registers the delay line, the outputs and the strap.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < PIPE_DEPTH; i++) begin
				pipe_r[i] <= '0;
			end
			pixel_out <= '0;
			pixel_data_clock_out <= 1'b0;
			regen_hsync_out <= 1'b0;
			sliced_sync_out <= 1'b0;
			field_odd_out <= 1'b0;
			strap_st_r <= sos_pkg::STRAP_WAIT;
			strap_r <= 1'b0;
			address_lsb_strap <= 1'b0;
			vsync_or_addr_pin_o <= 1'b0;
			vsync_or_addr_pin_oe_n <= 1'b1;
		end else if (clk_en) begin
			pipe_r <= pipe_nxt;
			pixel_out <= pipe_r[tap].pix;
			pixel_data_clock_out <= pipe_r[tap].clk;
			regen_hsync_out <= pipe_r[tap].hs ^ hs_ctrl_r[sos_pkg::HS_POL_BIT];
			sliced_sync_out <= slice_nxt_out;
			field_odd_out <= field_nxt;
			strap_st_r <= strap_st_nxt;
			strap_r <= strap_nxt;
			address_lsb_strap <= strap_nxt;
			vsync_or_addr_pin_o <= vsync_out_nxt;
			vsync_or_addr_pin_oe_n <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	regen_start_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && hs_rise |=> regen_r)
		else $error("regenerated sync did not start at line start");
	align_tap_a: assert property (@(posedge core_clk) disable iff (rst)
		$past(clk_en) |-> pixel_data_clock_out == $past(pipe_r[tap].clk) &&
		pixel_out == $past(pipe_r[tap].pix))
		else $error("data and clock left the common tap");
	vs_pass_a: assert property (@(posedge core_clk) disable iff (rst)
		$past(clk_en && !vs_ctrl_r[sos_pkg::VS_SEP_BIT] && !vs_ctrl_r[sos_pkg::VS_DUR_BIT])
		|-> vsync_out_r == $past(vsync_in ^ vs_ctrl_r[sos_pkg::VS_POL_BIT]))
		else $error("vertical sync pass through wrong");
	vs_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
		$past(clk_en) && vg_st_r == sos_pkg::VG_PULSE && $past(vs_ctrl_r[sos_pkg::VS_DUR_BIT])
		|-> vsync_out_r != $past(vs_ctrl_r[sos_pkg::VS_POL_BIT]))
		else $error("programmed vertical pulse not active");
	strap_cap_a: assert property (@(posedge core_clk) disable iff (rst)
		!rst && clk_en && strap_st_r == sos_pkg::STRAP_WAIT
		|=> address_lsb_strap == $past(vsync_or_addr_pin_i))
		else $error("address strap not captured");
	strap_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		$past(strap_st_r == sos_pkg::STRAP_DONE) |-> $stable(address_lsb_strap))
		else $error("address strap changed after capture");
	pin_drive_a: assert property (@(posedge core_clk) disable iff (rst)
		strap_st_r == sos_pkg::STRAP_DONE |-> !vsync_or_addr_pin_oe_n)
		else $error("shared pin not driven after strap capture");
	slice_raw_a: assert property (@(posedge core_clk) disable iff (rst)
		$past(clk_en && slice_r == sos_pkg::SL_RAW_HS)
		|-> sliced_sync_out == $past(horizontal_sync_in))
		else $error("sliced sync not the raw horizontal input");
	field_set_a: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && vs_rise |=> field_odd_out == $past(pos_r < (len_r >> 1)))
		else $error("field flag wrong at field start");
endmodule

// ### verification/sos_downstream_model.sv
// Downstream receiver model: board pull-up on the shared pin and sync-aligned capture.
`timescale 1ns/100ps
module sos_downstream_model #(
	parameter logic PULL_LEVEL = 1'b1
) (
	input wire logic core_clk,
	input wire logic pin_drive,
	input wire logic pin_drive_en_n,
	output logic shared_pin,
	input wire logic regen_hsync_out,
	input wire logic pixel_data_clock_out,
	input wire sos_pkg::sos_pixel_t pixel_out,
	output sos_pkg::sos_pixel_t cap_pix,
	output logic cap_clk
);
	logic hs_d; // Horizontal sync level seen at the previous edge.
	// The weak resistor sets the level only while the device leaves the pin undriven.
	assign shared_pin = pin_drive_en_n ? PULL_LEVEL : pin_drive;
	initial begin
		hs_d = 1'b0;
		cap_pix = '0;
		cap_clk = 1'b0;
	end
	// Data and data clock are strobed at the leading edge of horizontal sync.
	always @(posedge core_clk) begin
		hs_d <= regen_hsync_out;
		if (regen_hsync_out && !hs_d) begin
			cap_pix <= pixel_out;
			cap_clk <= pixel_data_clock_out;
		end
	end
endmodule

// ### verification/sos_sync_output_select_bench.sv
// Self-checking testbench of the sync output stage.
`timescale 1ns/100ps
module sos_sync_output_select_bench;
	// ------------------------------------------------------------
	// Stimulus, design and downstream model.
	// ------------------------------------------------------------
	logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic horizontal_sync_in = 1'b0, embedded_sync_in = 1'b0, vsync_in = 1'b0;
	logic pixel_clk_in = 1'b0, pin_i, pin_o, pin_oe_n, regen_hsync_out, pixel_data_clock_out;
	logic sliced_sync_out, field_odd_out, address_lsb_strap, cap_clk;
	logic [29:0] pix_cnt = 30'h0; // Running pixel value; bit 0 doubles as the data clock.
	sos_pkg::sos_pixel_t pixel_in, pixel_out, cap_pix;
	int fail_count = 0, compares = 0;
	assign pixel_in = sos_pkg::sos_pixel_t'(pix_cnt);
	// The clock toggles every 20 ns, a period of 40 ns.
	always #20 core_clk = ~core_clk;
	// Fresh pixel data each cycle, with a clock level that tracks its low bit.
	always @(posedge core_clk) begin
		pix_cnt <= pix_cnt + 30'h1;
		pixel_clk_in <= ~pix_cnt[0];
	end
	sos_sync_output_select #(.PIPE_DEPTH(8), .SEP_CYC(8)) sos_sync_output_select_i (
		.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.horizontal_sync_in(horizontal_sync_in), .embedded_sync_in(embedded_sync_in),
		.vsync_in(vsync_in), .pixel_clk_in(pixel_clk_in), .pixel_in(pixel_in),
		.vsync_or_addr_pin_i(pin_i), .vsync_or_addr_pin_o(pin_o),
		.vsync_or_addr_pin_oe_n(pin_oe_n), .regen_hsync_out(regen_hsync_out),
		.pixel_data_clock_out(pixel_data_clock_out), .pixel_out(pixel_out),
		.sliced_sync_out(sliced_sync_out), .field_odd_out(field_odd_out),
		.address_lsb_strap(address_lsb_strap));
	sos_downstream_model #(.PULL_LEVEL(1'b1)) sos_downstream_model_i (
		.core_clk(core_clk), .pin_drive(pin_o), .pin_drive_en_n(pin_oe_n), .shared_pin(pin_i),
		.regen_hsync_out(regen_hsync_out), .pixel_data_clock_out(pixel_data_clock_out),
		.pixel_out(pixel_out), .cap_pix(cap_pix), .cap_clk(cap_clk));
	// ------------------------------------------------------------
	// Shared tasks.
	// ------------------------------------------------------------
	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("Mismatches %0d, compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Compares a byte result.
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Compares a single output level.
	task automatic cmp1(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One-cycle register write.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// One-cycle register read; the data stand only in the following cycle.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Lines of 40 cycles with a 4-cycle horizontal pulse at the start.
	task automatic line(input int n);
		repeat (n) begin
			@(posedge core_clk);
			horizontal_sync_in <= 1'b1;
			repeat (4) @(posedge core_clk);
			horizontal_sync_in <= 1'b0;
			repeat (35) @(posedge core_clk);
		end
	endtask
	// Raises horizontal sync and measures latency and width of the regenerated pulse.
	task automatic hs_measure(input logic pol, output int lat, output int wid,
		output logic [7:0] p0);
		lat = 0;
		wid = 0;
		@(posedge core_clk);
		horizontal_sync_in <= 1'b1;
		#1 p0 = pix_cnt[7:0];
		while ((regen_hsync_out ^ pol) !== 1'b1 && lat < 30) begin
			@(posedge core_clk);
			#1 lat++;
		end
		while ((regen_hsync_out ^ pol) === 1'b1 && wid < 60) begin
			@(posedge core_clk);
			#1 wid++;
		end
		@(posedge core_clk);
		horizontal_sync_in <= 1'b0;
		repeat (8) @(posedge core_clk);
	endtask
	// ------------------------------------------------------------
	// Scenarios.
	// ------------------------------------------------------------
	// Reset values, unmapped read and the strap taken from the pulled-up pin.
	task automatic reset_test();
		logic [7:0] d;
		rd(sos_pkg::ADR_VS_DUR, d);
		cmp8(d, sos_pkg::RST_VS_DUR);
		rd(sos_pkg::ADR_HS_WIDTH, d);
		cmp8(d, sos_pkg::RST_HS_WIDTH);
		rd(8'h7F, d);
		cmp8(d, 8'h00);
		cmp1(address_lsb_strap, 1'b1);
		rd(sos_pkg::ADR_STATUS, d);
		cmp1(d[sos_pkg::ST_ADDR_BIT], 1'b1);
	endtask
	// Each of the four sliced sources is routed with nothing added.
	task automatic slice_test();
		for (int s = 0; s < 4; s++) begin
			wr(sos_pkg::ADR_SLICE, {6'h00, 2'(s)});
			@(posedge core_clk);
			if (s == 0) embedded_sync_in <= 1'b1;
			else horizontal_sync_in <= 1'b1;
			repeat (12) @(posedge core_clk);
			#1 cmp1(sliced_sync_out, 1'b1);
			@(posedge core_clk);
			embedded_sync_in <= 1'b0;
			horizontal_sync_in <= 1'b0;
			repeat (50) @(posedge core_clk);
			#1 cmp1(sliced_sync_out, 1'b0);
		end
	endtask
	// Programmed width, zero width and inverted polarity of the regenerated pulse.
	task automatic width_test();
		int lat, wid;
		logic [7:0] p0;
		wr(sos_pkg::ADR_HS_WIDTH, 8'h04);
		hs_measure(1'b0, lat, wid, p0);
		cmp8(8'(wid), 8'h04);
		wr(sos_pkg::ADR_HS_WIDTH, 8'h00);
		hs_measure(1'b0, lat, wid, p0);
		cmp8(8'(wid), 8'h01);
		wr(sos_pkg::ADR_HS_CTRL, 8'h01);
		repeat (4) @(posedge core_clk);
		#1 cmp1(regen_hsync_out, 1'b1);
		hs_measure(1'b1, lat, wid, p0);
		cmp8(8'(wid), 8'h01);
		wr(sos_pkg::ADR_HS_CTRL, 8'h00);
	endtask
	// Phase taps move sync, data and data clock by the same amount.
	task automatic phase_test();
		logic [2:0] taps [3] = '{3'h0, 3'h3, 3'h7};
		int lat, wid;
		logic [7:0] p0, base_lat, base_off;
		for (int i = 0; i < 3; i++) begin
			wr(sos_pkg::ADR_PHASE, {3'h0, taps[i], 2'h0});
			repeat (12) @(posedge core_clk);
			hs_measure(1'b0, lat, wid, p0);
			if (i == 0) begin
				base_lat = 8'(lat);
				base_off = cap_pix[7:0] - p0;
			end
			cmp8(8'(lat) - base_lat, {5'h00, taps[i]});
			cmp8(cap_pix[7:0] - p0, base_off);
			cmp1(cap_clk, cap_pix[0]);
		end
	endtask
	// Pulse on the embedded sync long enough to count as vertical sync.
	task automatic sep_pulse(input logic exp_after);
		@(posedge core_clk);
		embedded_sync_in <= 1'b1;
		repeat (20) @(posedge core_clk);
		#1 cmp1(pin_o, 1'b1);
		@(posedge core_clk);
		embedded_sync_in <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1 cmp1(pin_o, exp_after);
	endtask
	// Pass-through, inversion, separation and programmed duration of vertical sync.
	task automatic vert_test();
		@(posedge core_clk);
		vsync_in <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1 cmp1(pin_o, 1'b1);
		cmp1(pin_oe_n, 1'b0);
		wr(sos_pkg::ADR_VS_CTRL, 8'h04);
		repeat (2) @(posedge core_clk);
		#1 cmp1(pin_o, 1'b0);
		cmp1(address_lsb_strap, 1'b1);
		@(posedge core_clk);
		vsync_in <= 1'b0;
		wr(sos_pkg::ADR_VS_CTRL, 8'h08);
		sep_pulse(1'b0);
		wr(sos_pkg::ADR_VS_DUR, 8'h02);
		wr(sos_pkg::ADR_VS_CTRL, 8'h0A);
		sep_pulse(1'b1);
		line(6);
		#1 cmp1(pin_o, 1'b0);
		wr(sos_pkg::ADR_VS_CTRL, 8'h00);
	endtask
	// Vertical edge early in a line marks an odd field, late marks an even one.
	task automatic field_run(input int off, input logic exp);
		logic [7:0] d;
		@(posedge core_clk);
		vsync_in <= 1'b0;
		line(3);
		@(posedge core_clk);
		horizontal_sync_in <= 1'b1;
		repeat (4) @(posedge core_clk);
		horizontal_sync_in <= 1'b0;
		repeat (off - 4) @(posedge core_clk);
		vsync_in <= 1'b1;
		repeat (40 - off) @(posedge core_clk);
		line(2);
		#1 cmp1(field_odd_out, exp);
		rd(sos_pkg::ADR_STATUS, d);
		cmp1(d[sos_pkg::ST_FIELD_BIT], exp);
		cmp1(d[sos_pkg::ST_VS_BIT], 1'b1);
	endtask
	// A write strobe is ignored while the clock enable is low.
	task automatic gate_test();
		logic [7:0] d;
		@(posedge core_clk);
		clk_en <= 1'b0;
		wr(sos_pkg::ADR_HS_WIDTH, 8'h55);
		@(posedge core_clk);
		clk_en <= 1'b1;
		rd(sos_pkg::ADR_HS_WIDTH, d);
		cmp8(d, 8'h00);
	endtask
	// Main sequence: reset for 12 cycles, then every scenario in turn.
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		reset_test();
		slice_test();
		width_test();
		phase_test();
		vert_test();
		field_run(8, 1'b1);
		field_run(30, 1'b0);
		gate_test();
		close_out();
	end
	// Watchdog: the tests need under 1500 cycles; 20000 means a hang.
	initial begin
		#800000;
		fail_count++;
		close_out();
	end
endmodule
